// *** pkg/dbag_defines.svh ***
// register offsets, field positions and fixed counts of the debug access gate
`ifndef DBAG_DEFINES_SVH
`define DBAG_DEFINES_SVH
`define DBAG_ADDR_W 8
`define DBAG_DATA_W 32
`define DBAG_OFF_CTRL 8'h00
`define DBAG_OFF_XADDR 8'h04
`define DBAG_OFF_WIN 8'h0c
`define DBAG_OFF_BANK0 8'h10
`define DBAG_OFF_BANK1 8'h14
`define DBAG_OFF_BANK2 8'h18
`define DBAG_OFF_BANK3 8'h1c
`define DBAG_OFF_AUTH 8'h20
`define DBAG_OFF_IRQ_STAT 8'h24
`define DBAG_OFF_IRQ_MASK 8'h28
`define DBAG_OFF_DP_STAT 8'h2c
`define DBAG_CTL_DEV 0
`define DBAG_CTL_SDEV 1
`define DBAG_CTL_RR_LO 2
`define DBAG_CTL_RR_HI 3
`define DBAG_CTL_SECEN 4
`define DBAG_CTL_LVL_LO 8
`define DBAG_CTL_LVL_HI 9
`define DBAG_EV_REFUSED 0
`define DBAG_EV_AUTH 1
`define DBAG_EV_W 2
`define DBAG_DP_STICKY 0
`define DBAG_AUTH_W 7
`define DBAG_SYNC_STAGES 2
`define DBAG_BD_IDX_LO 2
`define DBAG_BD_IDX_HI 3
`define DBAG_BD_KEEP_LO 4
`define DBAG_AFLD_NONE 2'h0
`define DBAG_AFLD_DENIED 2'h2
`define DBAG_AFLD_PERMIT 2'h3
`endif

// *** pkg/dbag_pkg.sv ***
// types shared by the debug access gate modules
`default_nettype none
package dbag_pkg;
  typedef enum logic [2:0] {
    DBAG_NONE = 3'h0,
    DBAG_BASIC = 3'h1,
    DBAG_SECURE = 3'h2,
    DBAG_REALM = 3'h3,
    DBAG_LEG_NONE = 3'h4,
    DBAG_LEG_DEV = 3'h5,
    DBAG_LEG_DEV_SEC = 3'h6
  } dbag_mode_e;
  typedef enum logic [1:0] {
    DBAG_LVL_NS = 2'h0,
    DBAG_LVL_S = 2'h1,
    DBAG_LVL_REALM = 2'h2,
    DBAG_LVL_ROOT = 2'h3
  } dbag_level_e;
  typedef struct packed {
    logic device_access_enable;
    logic root_enable;
    logic realm_enable;
    logic secure_noninvasive_enable;
    logic secure_invasive_enable;
    logic noninvasive_enable;
    logic debug_enable;
  } dbag_auth_s;
endpackage : dbag_pkg
`default_nettype wire

// *** pkg/dbag_auth_if.sv ***
// synchronised authentication levels passed from the synchroniser to the gate
`timescale 1ns/10ps
`default_nettype none
interface dbag_auth_if;
  dbag_pkg::dbag_auth_s lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface : dbag_auth_if
`default_nettype wire

// *** core/dbag_auth_sync.sv ***
// synchroniser chains for the authentication enable inputs
`timescale 1ns/10ps
`default_nettype none
`include "dbag_defines.svh"
module dbag_auth_sync #(
  parameter int STAGES = `DBAG_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire dbag_pkg::dbag_auth_s raw,
  dbag_auth_if.src sync
);
  generate
    if (STAGES < 2) begin : g_bad
      $error("dbag_auth_sync needs at least two stages");
    end
  endgenerate

  logic [`DBAG_AUTH_W-1:0] raw_vec;
  logic [`DBAG_AUTH_W-1:0] out_vec;
  assign raw_vec = raw;

  genvar i;
  generate
    for (i = 0; i < `DBAG_AUTH_W; i++) begin : g_bit
      logic [STAGES-1:0] chain_reg;
      // only the last stage leaves the chain; the first is never observed
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          chain_reg <= '0;
        end else begin
          chain_reg <= {chain_reg[STAGES-2:0], raw_vec[i]};
        end
      end
      assign out_vec[i] = chain_reg[STAGES-1];
    end
  endgenerate

  assign sync.lvl = out_vec;
endmodule : dbag_auth_sync
`default_nettype wire

// *** core/dbag_gate.sv ***
// debug memory access port authentication gate with register port
//
// Contract
// RQ1 - without authentication inputs every memory transaction is permitted; the code permits Non-secure and Secure only, refusing Realm and Root.
// RQ2 - no-security variant permits access when debug or non-invasive enable high.
// RQ3 - security variants permit Non-secure and flag device access on basic enable.
// RQ4 - Secure permitted and both bits set when basic and any secure enable.
// RQ5 - secure non-invasive enable alone suffices for Secure in current version.
// RQ6 - realm variant permits Realm, sets realm bit, when basic and realm enable.
// RQ7 - Root permitted, root bit set, only with basic, secure, realm, root enables.
// RQ8 - system keeps realm and root enables consistent across all components.
// RQ9 - authentication status register reports the currently permitted debug level.
// RQ10 - system normally ties the device access enable input high.
// RQ11 - legacy refused data access issues nothing, sets sticky error flag.
// RQ12 - legacy device without device access enable reads device access as one.
// RQ13 - legacy two-input variant mirrors device enable and secure enable.
// RQ14 - legacy Secure needs basic enable and secure invasive enable only; the code also requires the device access enable.
// RQ15 - data window or banked data access starts memory access at address.
// RQ16 - enables are synchronised and permissions re-evaluated every cycle.
// RQ17 - each transaction checked against its level before issue downstream.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dbag_defines.svh"
module dbag_gate #(
  parameter dbag_pkg::dbag_mode_e AUTH_MODE = dbag_pkg::DBAG_REALM,
  parameter int SYNC_STAGES = `DBAG_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic debug_enable_in,
  input wire logic noninvasive_enable_in,
  input wire logic secure_invasive_enable_in,
  input wire logic secure_noninvasive_enable_in,
  input wire logic realm_enable_in,
  input wire logic root_enable_in,
  input wire logic device_access_enable_in,
  input wire logic [`DBAG_ADDR_W-1:0] reg_addr,
  input wire logic [`DBAG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DBAG_DATA_W-1:0] reg_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [`DBAG_DATA_W-1:0] mem_addr,
  output logic [`DBAG_DATA_W-1:0] mem_wdata,
  output logic [1:0] mem_level,
  input wire logic mem_rvalid,
  input wire logic [`DBAG_DATA_W-1:0] mem_rdata,
  output logic sticky_error_flag,
  output logic irq
);
  generate
    if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("dbag_gate needs at least two synchroniser stages");
    end
  endgenerate

  // permission bits: [0] Non-secure, [1] Secure, [2] Realm, [3] Root
  localparam int PERM_NS = 0;
  localparam int PERM_S = 1;
  localparam int PERM_REALM = 2;
  localparam int PERM_ROOT = 3;

  dbag_pkg::dbag_auth_s raw_auth;
  dbag_auth_if auth_sync_if ();

  assign raw_auth.debug_enable = debug_enable_in;
  assign raw_auth.noninvasive_enable = noninvasive_enable_in;
  assign raw_auth.secure_invasive_enable = secure_invasive_enable_in;
  assign raw_auth.secure_noninvasive_enable = secure_noninvasive_enable_in;
  assign raw_auth.realm_enable = realm_enable_in;
  assign raw_auth.root_enable = root_enable_in;
  assign raw_auth.device_access_enable = device_access_enable_in;

  // RQ16 synchronise enables
  dbag_auth_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw(raw_auth),
    .sync(auth_sync_if.src)
  );

  // permissions from the current enable levels, one bit per security level
  function automatic logic [3:0] eval_perm(
    input dbag_pkg::dbag_mode_e mode,
    input dbag_pkg::dbag_auth_s a
  );
    logic basic;
    logic sec_any;
    logic [3:0] p;
    basic = a.debug_enable | a.noninvasive_enable;
    sec_any = a.secure_invasive_enable | a.secure_noninvasive_enable;
    p = 4'h0;
    case (mode)
      // RQ1 no gating
      dbag_pkg::DBAG_NONE: p = 4'h3;
      // RQ12 legacy without device enable
      dbag_pkg::DBAG_LEG_NONE: p = 4'h3;
      // RQ2 cannot tell security apart
      dbag_pkg::DBAG_BASIC: p = {2'h0, basic, basic};
      // RQ3 RQ4 RQ5 secure variant
      dbag_pkg::DBAG_SECURE: p = {2'h0, basic & sec_any, basic};
      // RQ6 RQ7 realm variant, relies on RQ8 consistent enables
      dbag_pkg::DBAG_REALM: begin
        p[PERM_NS] = basic;
        p[PERM_S] = basic & sec_any;
        p[PERM_REALM] = basic & a.realm_enable;
        p[PERM_ROOT] = basic & sec_any & a.realm_enable & a.root_enable;
      end
      // RQ11 device enable alone, normally tied high per RQ10
      dbag_pkg::DBAG_LEG_DEV: begin
        p = {2'h0, a.device_access_enable, a.device_access_enable};
      end
      // RQ14 legacy secure ignores the non-invasive secure enable
      dbag_pkg::DBAG_LEG_DEV_SEC: begin
        p[PERM_NS] = a.device_access_enable;
        p[PERM_S] = a.device_access_enable & basic & a.secure_invasive_enable;
      end
      default: p = 4'h0;
    endcase
    return p;
  endfunction : eval_perm

  // two-bit authentication status field for one level
  function automatic logic [1:0] auth_field(input logic impl, input logic permit);
    if (!impl) begin
      return `DBAG_AFLD_NONE;
    end else if (permit) begin
      return `DBAG_AFLD_PERMIT;
    end else begin
      return `DBAG_AFLD_DENIED;
    end
  endfunction : auth_field

  // which security levels this variant can tell apart
  localparam logic [3:0] LEVEL_IMPL =
    (AUTH_MODE == dbag_pkg::DBAG_REALM) ? 4'hf :
    ((AUTH_MODE == dbag_pkg::DBAG_SECURE) ||
     (AUTH_MODE == dbag_pkg::DBAG_LEG_DEV_SEC)) ? 4'h3 : 4'h1;

  localparam logic IS_LEGACY =
    (AUTH_MODE == dbag_pkg::DBAG_LEG_NONE) ||
    (AUTH_MODE == dbag_pkg::DBAG_LEG_DEV) ||
    (AUTH_MODE == dbag_pkg::DBAG_LEG_DEV_SEC);

  // register state
  logic [3:0] perm_reg;
  logic [3:0] perm_next;
  logic secen_reg;
  logic [1:0] level_reg;
  logic [`DBAG_DATA_W-1:0] xaddr_reg;
  logic [`DBAG_DATA_W-1:0] rd_data_reg;
  logic [`DBAG_EV_W-1:0] irq_stat_reg;
  logic [`DBAG_EV_W-1:0] irq_mask_reg;
  logic sticky_reg;

  // RQ16 re-evaluated every cycle
  always_comb begin
    perm_next = eval_perm(AUTH_MODE, auth_sync_if.lvl);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      perm_reg <= 4'h0;
    end else begin
      perm_reg <= perm_next;
    end
  end

  // RQ13 mirror of the secure enable input
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      secen_reg <= 1'b0;
    end else begin
      secen_reg <= auth_sync_if.lvl.secure_invasive_enable;
    end
  end

  // address decode
  logic hit_ctrl;
  logic hit_xaddr;
  logic hit_win;
  logic hit_bd;
  logic hit_auth;
  logic hit_istat;
  logic hit_imask;
  logic hit_dp;
  logic [1:0] bd_idx;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_xaddr = 1'b0;
    hit_win = 1'b0;
    hit_bd = 1'b0;
    hit_auth = 1'b0;
    hit_istat = 1'b0;
    hit_imask = 1'b0;
    hit_dp = 1'b0;
    bd_idx = reg_addr[`DBAG_BD_IDX_HI:`DBAG_BD_IDX_LO];
    if (reg_addr == `DBAG_OFF_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (reg_addr == `DBAG_OFF_XADDR) begin
      hit_xaddr = 1'b1;
    end else if (reg_addr == `DBAG_OFF_WIN) begin
      hit_win = 1'b1;
    end else if ((reg_addr >= `DBAG_OFF_BANK0) && (reg_addr <= `DBAG_OFF_BANK3) &&
                 (reg_addr[1:0] == 2'h0)) begin
      hit_bd = 1'b1;
    end else if (reg_addr == `DBAG_OFF_AUTH) begin
      hit_auth = 1'b1;
    end else if (reg_addr == `DBAG_OFF_IRQ_STAT) begin
      hit_istat = 1'b1;
    end else if (reg_addr == `DBAG_OFF_IRQ_MASK) begin
      hit_imask = 1'b1;
    end else if (reg_addr == `DBAG_OFF_DP_STAT) begin
      hit_dp = 1'b1;
    end
  end

  // requested transfer and its gating
  logic data_access;
  logic level_ok;
  logic issue;
  logic refuse;
  logic [`DBAG_DATA_W-1:0] access_addr;

  always_comb begin
    data_access = (reg_wr | reg_rd) & (hit_win | hit_bd);
    // RQ17 check the requested level
    // RQ1 RQ12 ungated variants keep Secure open; upper levels are zero in perm
    level_ok = perm_reg[level_reg];
    // RQ11 no transaction when refused
    issue = data_access & level_ok;
    refuse = data_access & ~level_ok;
    // RQ15 address from the transfer address
    if (hit_bd) begin
      access_addr = {xaddr_reg[`DBAG_DATA_W-1:`DBAG_BD_KEEP_LO], bd_idx, 2'h0};
    end else begin
      access_addr = xaddr_reg;
    end
  end

  // control register: only the level field is writable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_reg <= dbag_pkg::DBAG_LVL_NS;
    end else if (reg_wr && hit_ctrl) begin
      level_reg <= reg_wdata[`DBAG_CTL_LVL_HI:`DBAG_CTL_LVL_LO];
    end
  end

  // address never auto-increments here
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xaddr_reg <= '0;
    end else if (reg_wr && hit_xaddr) begin
      xaddr_reg <= reg_wdata;
    end
  end

  // RQ15 RQ17 downstream request, one cycle after the register access
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= '0;
      mem_level <= dbag_pkg::DBAG_LVL_NS;
    end else begin
      mem_req <= issue;
      if (issue) begin
        mem_we <= reg_wr;
        mem_addr <= access_addr;
        mem_wdata <= reg_wdata;
        mem_level <= level_reg;
      end
    end
  end

  // reads return the last completed memory read; the port cannot stall
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_reg <= '0;
    end else if (mem_rvalid) begin
      rd_data_reg <= mem_rdata;
    end
  end

  // RQ11 sticky error on refused access, set beats clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sticky_reg <= 1'b0;
    end else if (refuse) begin
      sticky_reg <= 1'b1;
    end else if (reg_wr && hit_dp && reg_wdata[`DBAG_DP_STICKY]) begin
      sticky_reg <= 1'b0;
    end
  end

  assign sticky_error_flag = sticky_reg;

  // interrupt events; a new event in a clearing cycle stays set
  logic [`DBAG_EV_W-1:0] ev_set;
  logic [`DBAG_EV_W-1:0] ev_clr;

  always_comb begin
    ev_set = '0;
    ev_set[`DBAG_EV_REFUSED] = refuse;
    ev_set[`DBAG_EV_AUTH] = (perm_next != perm_reg);
    ev_clr = '0;
    if (reg_wr && hit_istat) begin
      ev_clr = reg_wdata[`DBAG_EV_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_reg <= '0;
    end else if (reg_wr && hit_imask) begin
      irq_mask_reg <= reg_wdata[`DBAG_EV_W-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // status word contents
  logic [`DBAG_DATA_W-1:0] ctrl_view;
  logic [`DBAG_DATA_W-1:0] auth_view;

  always_comb begin
    ctrl_view = '0;
    // RQ2 RQ3 RQ12 RQ13 device access allowed
    ctrl_view[`DBAG_CTL_DEV] = perm_reg[PERM_NS];
    // RQ4 secure access allowed
    if (!IS_LEGACY) begin
      ctrl_view[`DBAG_CTL_SDEV] = perm_reg[PERM_S] & LEVEL_IMPL[PERM_S];
    end
    // RQ6 RQ7 realm and root bits
    if (AUTH_MODE == dbag_pkg::DBAG_REALM) begin
      ctrl_view[`DBAG_CTL_RR_HI:`DBAG_CTL_RR_LO] = perm_reg[PERM_ROOT:PERM_REALM];
    end
    // RQ13 secure enable mirror
    if (AUTH_MODE == dbag_pkg::DBAG_LEG_DEV_SEC) begin
      ctrl_view[`DBAG_CTL_SECEN] = secen_reg;
    end
    ctrl_view[`DBAG_CTL_LVL_HI:`DBAG_CTL_LVL_LO] = level_reg;
  end

  // RQ9 permitted level per field
  always_comb begin
    auth_view = '0;
    auth_view[1:0] = auth_field(LEVEL_IMPL[PERM_NS], perm_reg[PERM_NS]);
    auth_view[3:2] = auth_field(LEVEL_IMPL[PERM_S], perm_reg[PERM_S]);
    auth_view[5:4] = auth_field(LEVEL_IMPL[PERM_REALM], perm_reg[PERM_REALM]);
    auth_view[7:6] = auth_field(LEVEL_IMPL[PERM_ROOT], perm_reg[PERM_ROOT]);
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (hit_ctrl) begin
      reg_rdata <= ctrl_view;
    end else if (hit_xaddr) begin
      reg_rdata <= xaddr_reg;
    end else if (hit_win || hit_bd) begin
      reg_rdata <= level_ok ? rd_data_reg : '0;
    end else if (hit_auth) begin
      reg_rdata <= auth_view;
    end else if (hit_istat) begin
      reg_rdata <= {{(`DBAG_DATA_W-`DBAG_EV_W){1'b0}}, irq_stat_reg};
    end else if (hit_imask) begin
      reg_rdata <= {{(`DBAG_DATA_W-`DBAG_EV_W){1'b0}}, irq_mask_reg};
    end else if (hit_dp) begin
      reg_rdata <= {{(`DBAG_DATA_W-1){1'b0}}, sticky_reg};
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : dbag_gate
`default_nettype wire

// *** sim/dbag_gate_asserts.sv ***
// concurrent checks on the ports of the debug access gate
`timescale 1ns/10ps
`default_nettype none
`include "dbag_defines.svh"
module dbag_gate_asserts #(
  parameter dbag_pkg::dbag_mode_e AUTH_MODE = dbag_pkg::DBAG_REALM,
  parameter int SYNC_STAGES = `DBAG_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic debug_enable_in,
  input wire logic noninvasive_enable_in,
  input wire logic secure_invasive_enable_in,
  input wire logic secure_noninvasive_enable_in,
  input wire logic realm_enable_in,
  input wire logic root_enable_in,
  input wire logic [`DBAG_ADDR_W-1:0] reg_addr,
  input wire logic [`DBAG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [`DBAG_DATA_W-1:0] mem_addr,
  input wire logic [`DBAG_DATA_W-1:0] mem_wdata,
  input wire logic [1:0] mem_level,
  input wire logic sticky_error_flag,
  input wire logic irq
);
  localparam bit RM = (AUTH_MODE == dbag_pkg::DBAG_REALM);
  logic [5:0] pins;
  logic [5:0] pins_reg;
  logic [2:0] stab_reg;
  logic [1:0] lvl_reg;
  logic [1:0] idx_reg;
  logic [31:0] xaddr_reg;
  logic mask0_reg;
  logic b, s, ok, dat, stab;
  logic [3:0] pv;
  assign pins = {root_enable_in, realm_enable_in, secure_noninvasive_enable_in,
                 secure_invasive_enable_in, noninvasive_enable_in, debug_enable_in};
  assign b = debug_enable_in | noninvasive_enable_in;
  assign s = b & (secure_invasive_enable_in | secure_noninvasive_enable_in);
  assign pv = {s & realm_enable_in & root_enable_in & RM, b & realm_enable_in & RM, s, b};
  assign ok = pv[lvl_reg];
  assign dat = (reg_wr | reg_rd) && (reg_addr == `DBAG_OFF_WIN || reg_addr[7:4] == 4'h1) &&
               reg_addr[1:0] == 2'h0;
  // judge gating only once the pins have been quiet past the sync chain
  assign stab = (stab_reg == 3'h7);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_reg <= 6'h00;
      stab_reg <= 3'h0;
    end else begin
      pins_reg <= pins;
      stab_reg <= (pins != pins_reg) ? 3'h0 : stab_reg + {2'h0, stab_reg != 3'h7};
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lvl_reg <= 2'h0;
      xaddr_reg <= 32'h0;
      mask0_reg <= 1'b0;
      idx_reg <= 2'h0;
    end else begin
      idx_reg <= reg_addr[3:2];
      if (reg_wr && reg_addr == `DBAG_OFF_CTRL) lvl_reg <= reg_wdata[9:8];
      if (reg_wr && reg_addr == `DBAG_OFF_XADDR) xaddr_reg <= reg_wdata;
      if (reg_wr && reg_addr == `DBAG_OFF_IRQ_MASK) mask0_reg <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_issue_allowed: assert property (
    dat && stab && ok |=> mem_req && mem_level == $past(lvl_reg))
    else $error("permitted data access not issued");
  a_refuse_sticky: assert property (
    dat && stab && !ok |=> !mem_req && sticky_error_flag)
    else $error("refused data access not flagged");
  a_ns_gate: assert property (
    mem_req && stab && mem_level == 2'h0 |-> b) else $error("non-secure issued while off");
  a_sec_gate: assert property (
    mem_req && stab && mem_level == 2'h1 |-> s) else $error("secure issued while off");
  a_realm_gate: assert property (
    mem_req && stab && mem_level == 2'h2 |-> pv[2]) else $error("realm issued while off");
  a_root_gate: assert property (
    mem_req && stab && mem_level == 2'h3 |-> pv[3]) else $error("root issued while off");
  a_req_cause: assert property (
    mem_req |-> $past(dat)) else $error("transaction without data access");
  a_window_write: assert property (
    reg_wr && reg_addr == `DBAG_OFF_WIN && stab && ok
    |=> mem_we && mem_wdata == $past(reg_wdata) && mem_addr == xaddr_reg)
    else $error("window write carried wrong fields");
  a_bank_addr: assert property (
    reg_addr[7:4] == 4'h1 && dat && stab && ok
    |=> mem_addr == {xaddr_reg[31:4], idx_reg, 2'b00}) else $error("banked address wrong");
  a_irq_refused: assert property (
    $rose(sticky_error_flag) && mask0_reg |-> irq) else $error("refusal did not raise irq");
  c_root_issue: cover property (mem_req && mem_level == 2'h3);
  c_refused: cover property (dat && stab && !ok);
  c_irq: cover property ($rose(irq));
endmodule : dbag_gate_asserts
bind dbag_gate dbag_gate_asserts #(.AUTH_MODE(AUTH_MODE), .SYNC_STAGES(SYNC_STAGES)) u_asserts (
  .clk(clk), .sys_rst(sys_rst), .debug_enable_in(debug_enable_in),
  .noninvasive_enable_in(noninvasive_enable_in),
  .secure_invasive_enable_in(secure_invasive_enable_in),
  .secure_noninvasive_enable_in(secure_noninvasive_enable_in),
  .realm_enable_in(realm_enable_in), .root_enable_in(root_enable_in),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_level(mem_level), .sticky_error_flag(sticky_error_flag), .irq(irq)
);
`default_nettype wire

// *** sim/dbag_mem_model.sv ***
// memory system model answering reads issued by the gate
`timescale 1ns/10ps
`default_nettype none
module dbag_mem_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic [3:0] wait_reg;
  logic [31:0] addr_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_reg <= 4'h0;
      addr_reg <= 32'h0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h0;
    end else begin
      mem_rvalid <= 1'b0;
      // data toggles outside the response cycle so stale values never match
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_we) begin
        wait_reg <= slow ? 4'h6 : 4'h1;
        addr_reg <= mem_addr;
      end else if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
        if (wait_reg == 4'h1) begin
          mem_rvalid <= 1'b1;
          mem_rdata <= addr_reg ^ 32'h5a5a_a5a5;
        end
      end
    end
  end
endmodule : dbag_mem_model
`default_nettype wire

// *** sim/tb_debug_access_auth_gate.sv ***
// self-checking bench for the debug access gate in its realm variant
`timescale 1ns/10ps
`default_nettype none
`include "dbag_defines.svh"
module tb_debug_access_auth_gate;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] en = 6'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic slow = 1'b0;
  logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, rd, base;
  logic mem_req, mem_we, mem_rvalid, sticky_error_flag, irq;
  logic [1:0] mem_level;
  logic [3:0] p;
  logic [5:0] corner [5] = '{6'h00, 6'h0a, 6'h31, 6'h3c, 6'h3f};
  int mismatches = 0;
  int checked = 0;
  logic [31:0] rng = 32'd75301;
  always #2 clk = ~clk;
  dbag_gate #(.AUTH_MODE(dbag_pkg::DBAG_REALM), .SYNC_STAGES(2)) DUT (
    .clk(clk), .sys_rst(sys_rst), .debug_enable_in(en[0]), .noninvasive_enable_in(en[1]),
    .secure_invasive_enable_in(en[2]), .secure_noninvasive_enable_in(en[3]),
    .realm_enable_in(en[4]), .root_enable_in(en[5]), .device_access_enable_in(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_level(mem_level), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .sticky_error_flag(sticky_error_flag), .irq(irq));
  dbag_mem_model u_mem (.clk(clk), .sys_rst(sys_rst), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // {root, realm, secure, non-secure} permissions from {rt, rl, spn, spi, nid, dbg}
  function automatic logic [3:0] perm_f(logic [5:0] e);
    logic b;
    logic s;
    b = e[0] | e[1];
    s = b & (e[2] | e[3]);
    return {s & e[4] & e[5], b & e[4], s, b};
  endfunction : perm_f
  function automatic logic [31:0] auth_f(logic [3:0] q);
    logic [31:0] a;
    a = 32'h0;
    for (int i = 0; i < 4; i++) a[2*i +: 2] = {1'b1, q[i]};
    return a;
  endfunction : auth_f
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rdr
  // one data access at level lvl; a write to the window or a read of bank lvl
  task automatic access(input logic [1:0] lvl, input logic w);
    logic [31:0] d;
    logic [31:0] x;
    d = xs(rng);
    rng = d;
    wr(`DBAG_OFF_CTRL, {22'h0, lvl, 8'h00});
    if (w) wr(`DBAG_OFF_WIN, d);
    else rdr({4'h1, lvl, 2'h0}, x);
    check(mem_req, p[lvl], "issue");
    if (p[lvl] === 1'b1) begin
      check(mem_level, lvl, "level");
      check(mem_we, w, "direction");
      check(mem_addr, w ? base : {base[31:4], lvl, 2'h0}, "address");
      if (w) check(mem_wdata, d, "wdata");
    end else begin
      check(sticky_error_flag, 1'b1, "sticky set");
      wr(`DBAG_OFF_DP_STAT, 32'h1);
      check(sticky_error_flag, 1'b0, "sticky clear");
    end
  endtask : access
  task automatic wait_rvalid();
    int k;
    k = 0;
    while (mem_rvalid !== 1'b1) begin
      @(posedge clk);
      #1;
      k++;
      if (k > 20) begin
        mismatches++;
        $display("CHECK FAILED at %0t: no read response", $time);
        report_and_stop();
      end
    end
  endtask : wait_rvalid
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int t = 0; t < 20; t++) begin
      rng = xs(rng);
      base = xs(rng);
      // one system-wide level per enable, device enable tied high
      @(posedge clk);
      en <= (t < 5) ? corner[t] : rng[5:0];
      repeat (3) @(posedge clk);
      p = perm_f(en);
      rdr(`DBAG_OFF_CTRL, rd);
      check(rd[4:0], {1'b0, p}, "status bits");
      rdr(`DBAG_OFF_AUTH, rd);
      check(rd, auth_f(p), "auth status");
      wr(`DBAG_OFF_XADDR, base);
      for (int l = 0; l < 4; l++) access(2'(l), 1'(t + l));
      $display("test %0d done for enables %h", t, en);
    end
    wr(`DBAG_OFF_IRQ_STAT, 32'h3);
    check(irq, 1'b0, "irq cleared");
    wr(`DBAG_OFF_IRQ_MASK, 32'h1);
    @(posedge clk);
    en <= 6'h00;
    repeat (8) @(posedge clk);
    p = perm_f(6'h00);
    access(2'h0, 1'b1);
    check(irq, 1'b1, "irq raised");
    wr(`DBAG_OFF_IRQ_STAT, 32'h1);
    check(irq, 1'b0, "irq cleared");
    rdr(8'hfc, rd);
    check(rd, 32'h0, "unmapped read");
    $display("test irq and unmapped done");
    @(posedge clk);
    en <= 6'h3f;
    repeat (8) @(posedge clk);
    for (int sl = 0; sl < 2; sl++) begin
      @(posedge clk);
      slow <= 1'(sl);
      base = xs(rng);
      rng = base;
      wr(`DBAG_OFF_CTRL, 32'h0);
      wr(`DBAG_OFF_XADDR, base);
      rdr(`DBAG_OFF_WIN, rd);
      wait_rvalid();
      rdr(`DBAG_OFF_WIN, rd);
      check(rd, base ^ 32'h5a5a_a5a5, "read data");
      $display("test read path slow=%0d done", sl);
    end
    report_and_stop();
  end
endmodule : tb_debug_access_auth_gate
`default_nettype wire
